// ### hw/panel_status_pkg.sv
// Constants and types of the panel status logic.
// Assumes a 125 MHz clock; times are held as clock counts.
package panel_status_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ          = 125;
	localparam int unsigned MSG_HOLD_MS      = 2000;
	localparam int unsigned CYCLES_PER_MS    = CLK_MHZ * 1000;
	localparam int unsigned MSG_HOLD_CYCLES  = MSG_HOLD_MS * CYCLES_PER_MS;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned SLOT_COUNT   = 6;
	localparam int unsigned ROW_COUNT    = 8;
	localparam int unsigned COL_PER_SLOT = 12;
	localparam int unsigned XP_COUNT     = SLOT_COUNT * ROW_COUNT * COL_PER_SLOT;
	localparam int unsigned ROW_BLOCKS   = 2;
	localparam int unsigned SETTLE_W     = 17;
	localparam int unsigned CARD_SETTLE_W = 8;
	localparam int unsigned XP_ADDR_W    = 10;
	localparam int unsigned ROW_SEL_W    = 4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic        RST_EDGE_RISING  = 1'h0;
	localparam logic        RST_READY_HIGH   = 1'h0;
	localparam logic        RST_TRIG_ENABLE  = 1'h0;
	localparam logic [16:0] RST_USER_SETTLE  = 17'h00000;
	localparam logic [16:0] USER_SETTLE_MAX  = 17'h1869f;

	// ****************************************************************
	// Enumerations
	// ****************************************************************
	typedef enum logic [2:0] {
		SRC_EXTERNAL,
		SRC_KEY,
		SRC_TALK,
		SRC_GET,
		SRC_EXEC_CHAR
	} trig_source_type;

	typedef enum logic [3:0] {
		MSG_NONE,
		MSG_CARD_ID,
		MSG_BAD_CMD,
		MSG_BAD_OPTION,
		MSG_INVALID_INPUT,
		MSG_POINTER,
		MSG_LOOP_ERROR,
		MSG_LOOP_DOWN,
		MSG_NOT_REMOTE,
		MSG_RAM_FAIL,
		MSG_ROM_FAIL,
		MSG_SETUP_ERROR,
		MSG_TRIGGER_OVERRUN_FLAG,
		MSG_UNSETTLED_TRIGGER_FLAG
	} message_type;

	typedef enum logic [1:0] {
		ST_READY,
		ST_SETTLE_CARD,
		ST_SETTLE_USER
	} settle_state_type;

endpackage : panel_status_pkg

// ### hw/matrix_panel_status_logic.sv
// Status, trigger, settling, lamp and row logic of a switching matrix panel.
// Assumes one-cycle strobes on clk_in; the trigger pin is asynchronous.
//
// How it works
// RQ1: Persistent errors hold until next operation.
// RQ2: Other errors show two seconds, then revert.
// RQ3: Trigger before ready raises overrun flag.
// RQ4: Trigger before settle end flags, still processed.
// RQ5: External trigger edge selectable falling or rising.
// RQ6: Matrix ready polarity selectable low or high.
// RQ7: Five selectable trigger sources.
// RQ8: User settle milliseconds added to card settle.
// RQ9: Card settle is longest installed card's.
// RQ10: Loop faults report loop error.
// RQ11: Unpowered loop unit reports loop down.
// RQ12: Execute character outside remote reports error.
// RQ13: Listen addressed with REN enters remote.
// RQ14: Remote ignores panel except local key; in remote, pen misses and bad row indexes still post messages.
// RQ15: Local key returns local unless lockout.
// RQ16: Talk, listen lamps follow addressing.
// RQ17: Crosspoint lamps six blocks of 8x12.
// RQ18: Row selections kept in two column blocks.
// RQ19: Row holds one sequencing mode only.
// RQ20: Out-of-range entries flag invalid input.
// RQ21: Pen off target flags pointer error.
// RQ22: Two distinct bus command errors.
// RQ23: Setup checksum error clears setup, continue.
// RQ24: Card checksum fail reports identity error.
// RQ25: Reset defaults: fall, low, disabled, external, zero.
// RQ26: Ready only after combined settle interval.
`timescale 1ns/1ps

module matrix_panel_status_logic
#(
	parameter int unsigned MSG_HOLD_CYCLES = panel_status_pkg::MSG_HOLD_CYCLES,
	parameter int unsigned CYCLES_PER_MS   = panel_status_pkg::CYCLES_PER_MS
)
(
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         external_trigger_input_in,
	input  wire logic         key_trigger_in,
	input  wire logic         talk_trigger_in,
	input  wire logic         get_trigger_in,
	input  wire logic         exec_char_in,
	input  wire logic         trig_enable_in,
	input  wire logic         cfg_write_in,
	input  wire logic [2:0]   cfg_source_in,
	input  wire logic         cfg_edge_rising_in,
	input  wire logic         cfg_ready_high_in,
	input  wire logic [16:0]  cfg_user_settle_in,
	input  wire logic         relay_change_in,
	input  wire logic [47:0]  card_settle_in,
	input  wire logic [5:0]   card_present_in,
	input  wire logic [5:0]   card_id_fail_in,
	input  wire logic         loop_fault_in,
	input  wire logic         loop_down_in,
	input  wire logic         ram_fail_in,
	input  wire logic         rom_fail_in,
	input  wire logic         setup_checksum_fail_in,
	input  wire logic         bad_command_error_in,
	input  wire logic         bad_command_option_error_in,
	input  wire logic         operation_in,
	input  wire logic         listen_addressed_in,
	input  wire logic         talk_addressed_in,
	input  wire logic         ren_in,
	input  wire logic         llo_in,
	input  wire logic         local_key_in,
	input  wire logic         panel_key_in,
	input  wire logic         xp_write_in,
	input  wire logic [9:0]   xp_addr_in,
	input  wire logic         xp_value_in,
	input  wire logic         row_sel_in,
	input  wire logic [3:0]   row_index_in,
	input  wire logic         row_block_in,
	input  wire logic         row_break_make_in,
	input  wire logic         entry_invalid_in,
	input  wire logic         pen_press_in,
	input  wire logic         pen_on_target_in,
	output logic              matrix_ready_out,
	output logic              trigger_out,
	output logic              trigger_overrun_flag_out,
	output logic              unsettled_trigger_flag_out,
	output logic [3:0]        message_out,
	output logic              remote_led_out,
	output logic              talk_led_out,
	output logic              listen_led_out,
	output logic [575:0]      crosspoint_led_out,
	output logic [15:0]       make_break_rows_out,
	output logic [15:0]       break_make_rows_out,
	output logic              clear_setup_out,
	output logic [7:0]        card_settle_time_out,
	output logic              edge_rising_out,
	output logic              ready_high_out,
	output logic [2:0]        source_out,
	output logic              trig_enabled_out,
	output logic [16:0]       user_settle_time_out
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                              rst_meta;
		logic                              rst_sync;
		logic [2:0]                        ext_sync;
		logic                              ext_level;
		logic                              edge_rising;
		logic                              ready_high;
		panel_status_pkg::trig_source_type source;
		logic                              trig_en;
		logic [16:0]                       user_settle;
		logic [7:0]                        card_settle;
		panel_status_pkg::settle_state_type settle;
		logic [16:0]                       ms_left;
		logic [31:0]                       cyc_left;
		logic                              settled;
		logic                              ready;
		logic                              trig;
		logic                              overrun;
		logic                              unsettled;
		panel_status_pkg::message_type     msg;
		panel_status_pkg::message_type     msg_prev;
		logic                              msg_sticky;
		logic [31:0]                       msg_timer;
		logic                              remote;
		logic                              talk;
		logic                              listen;
		logic [575:0]                      xp;
		logic [15:0]                       mb_rows;
		logic [15:0]                       bm_rows;
		logic                              clear_setup;
	} state_type;

	state_type state_ff;
	state_type nxt_state;
	logic      rst_n;
	logic      ext_edge;
	logic      trig_hit;
	logic [7:0] longest;
	logic [3:0] row_bit;
	logic      op;

	assign rst_n = state_ff.rst_sync;

	// ****************************************************************
	// Longest installed card settle time
	// ****************************************************************
	always_comb
	begin
		longest = 8'h00;
		for (int i = 0; i < panel_status_pkg::SLOT_COUNT; i++)
		begin
			if (card_present_in[i] && card_settle_in[i*8 +: 8] > longest)
				longest = card_settle_in[i*8 +: 8]; // RQ9
		end
	end

	// Edge seen once the 2nd and 3rd stages agree on a new level
	always_comb
	begin
		ext_edge = 1'b0;
		if (state_ff.ext_sync[2] == state_ff.ext_sync[1]
			&& state_ff.ext_sync[1] != state_ff.ext_level)
			ext_edge = (state_ff.ext_sync[1] == state_ff.edge_rising); // RQ5
	end

	// Source mux; only the chosen source fires
	always_comb
	begin
		case (state_ff.source) // RQ7
			panel_status_pkg::SRC_EXTERNAL:  trig_hit = ext_edge;
			panel_status_pkg::SRC_KEY:       trig_hit = key_trigger_in && !state_ff.remote;
			panel_status_pkg::SRC_TALK:      trig_hit = talk_trigger_in;
			panel_status_pkg::SRC_GET:       trig_hit = get_trigger_in;
			panel_status_pkg::SRC_EXEC_CHAR: trig_hit = exec_char_in && state_ff.remote;
			default:                         trig_hit = 1'b0;
		endcase
	end

	assign row_bit = {row_block_in, row_index_in[2:0]};
	// A panel key counts as an operation only in local
	assign op = operation_in || (panel_key_in && !state_ff.remote); // RQ14

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.rst_meta = 1'b1;
		nxt_state.rst_sync = state_ff.rst_meta;
		nxt_state.ext_sync = {state_ff.ext_sync[1:0], external_trigger_input_in};
		if (state_ff.ext_sync[2] == state_ff.ext_sync[1])
			nxt_state.ext_level = state_ff.ext_sync[1];
		nxt_state.trig = 1'b0;
		nxt_state.clear_setup = 1'b0;
		nxt_state.card_settle = longest; // RQ9
		nxt_state.trig_en = trig_enable_in;

		// Config writes; panel writes refused in remote
		if (cfg_write_in && !state_ff.remote) // RQ14
		begin
			nxt_state.edge_rising = cfg_edge_rising_in; // RQ5
			nxt_state.ready_high  = cfg_ready_high_in; // RQ6
			if (cfg_source_in <= 3'h4)
				nxt_state.source = panel_status_pkg::trig_source_type'(cfg_source_in);
			if (cfg_user_settle_in <= panel_status_pkg::USER_SETTLE_MAX)
				nxt_state.user_settle = cfg_user_settle_in; // RQ8
		end

		// Trigger flags; a set in the same cycle wins over the clear
		if (op)
		begin
			nxt_state.overrun   = 1'b0;
			nxt_state.unsettled = 1'b0;
		end
		if (state_ff.trig_en && trig_hit)
		begin
			nxt_state.trig = 1'b1; // RQ4
			if (!state_ff.ready)
				nxt_state.overrun = 1'b1; // RQ3
			if (!state_ff.settled)
				nxt_state.unsettled = 1'b1; // RQ4
		end

		// Settling sequencer: card time then user time, ms resolution
		case (state_ff.settle)
			panel_status_pkg::ST_READY:
			begin
				if (relay_change_in || nxt_state.trig)
				begin
					nxt_state.settle   = panel_status_pkg::ST_SETTLE_CARD;
					nxt_state.ms_left  = {9'h000, state_ff.card_settle};
					nxt_state.cyc_left = CYCLES_PER_MS;
					nxt_state.ready    = 1'b0;
					nxt_state.settled  = 1'b0;
				end
			end
			panel_status_pkg::ST_SETTLE_CARD, panel_status_pkg::ST_SETTLE_USER:
			begin
				if (state_ff.ms_left == 17'h00000)
				begin
					if (state_ff.settle == panel_status_pkg::ST_SETTLE_CARD)
					begin
						nxt_state.settle  = panel_status_pkg::ST_SETTLE_USER;
						nxt_state.ms_left = state_ff.user_settle; // RQ8
					end
					else
					begin
						nxt_state.settle  = panel_status_pkg::ST_READY;
						nxt_state.ready   = 1'b1; // RQ26
						nxt_state.settled = 1'b1;
					end
				end
				else if (state_ff.cyc_left <= 32'h00000001)
				begin
					nxt_state.ms_left  = state_ff.ms_left - 17'h00001;
					nxt_state.cyc_left = CYCLES_PER_MS;
				end
				else
					nxt_state.cyc_left = state_ff.cyc_left - 32'h00000001;
			end
			default: nxt_state.settle = panel_status_pkg::ST_READY;
		endcase

		// Bus state: remote entry, local return, addressing lamps
		nxt_state.talk   = talk_addressed_in; // RQ16
		nxt_state.listen = listen_addressed_in; // RQ16
		if (!ren_in)
			nxt_state.remote = 1'b0;
		else if (listen_addressed_in)
			nxt_state.remote = 1'b1; // RQ13
		else if (local_key_in && !llo_in)
			nxt_state.remote = 1'b0; // RQ15

		// Crosspoint lamps, refused in remote
		if (xp_write_in && !state_ff.remote) // RQ14
		begin
			if (xp_addr_in < 10'(panel_status_pkg::XP_COUNT))
				nxt_state.xp[xp_addr_in] = xp_value_in; // RQ17
		end
		// Failed card lights its whole block
		for (int s = 0; s < panel_status_pkg::SLOT_COUNT; s++)
		begin
			if (card_id_fail_in[s])
				nxt_state.xp[s*96 +: 96] = {96{1'b1}}; // RQ24
		end

		// Row sequencing selection, exclusive between modes
		if (row_sel_in && !state_ff.remote && row_index_in < 4'h8) // RQ14
		begin
			if (row_break_make_in)
			begin
				nxt_state.bm_rows[row_bit] = 1'b1; // RQ18
				nxt_state.mb_rows[row_bit] = 1'b0; // RQ19
			end
			else
			begin
				nxt_state.mb_rows[row_bit] = 1'b1; // RQ18
				nxt_state.bm_rows[row_bit] = 1'b0; // RQ19
			end
		end

		if (setup_checksum_fail_in)
			nxt_state.clear_setup = 1'b1; // RQ23

		// Message handling: persistent ones wait for an operation
		if (state_ff.msg != panel_status_pkg::MSG_NONE)
		begin
			if (state_ff.msg_sticky)
			begin
				if (op)
				begin
					nxt_state.msg = panel_status_pkg::MSG_NONE; // RQ1
					nxt_state.msg_sticky = 1'b0;
				end
			end
			else if (state_ff.msg_timer <= 32'h00000001)
			begin
				nxt_state.msg = state_ff.msg_prev; // RQ2
				nxt_state.msg_sticky = state_ff.msg_prev != panel_status_pkg::MSG_NONE;
			end
			else
				nxt_state.msg_timer = state_ff.msg_timer - 32'h00000001;
		end

		// New message, highest priority last
		begin : post
			panel_status_pkg::message_type m;
			logic sticky;
			m = panel_status_pkg::MSG_NONE;
			sticky = 1'b0;
			if (state_ff.trig_en && trig_hit && !state_ff.settled)
				m = panel_status_pkg::MSG_UNSETTLED_TRIGGER_FLAG; // RQ4
			if (state_ff.trig_en && trig_hit && !state_ff.ready)
				m = panel_status_pkg::MSG_TRIGGER_OVERRUN_FLAG; // RQ3
			if (exec_char_in && !state_ff.remote)
				m = panel_status_pkg::MSG_NOT_REMOTE; // RQ12
			if (entry_invalid_in || (xp_write_in && !state_ff.remote
				&& xp_addr_in >= 10'(panel_status_pkg::XP_COUNT))
				|| (row_sel_in && row_index_in >= 4'h8)
				|| (cfg_write_in && !state_ff.remote && (cfg_source_in > 3'h4
				|| cfg_user_settle_in > panel_status_pkg::USER_SETTLE_MAX)))
				m = panel_status_pkg::MSG_INVALID_INPUT; // RQ20
			if (pen_press_in && !pen_on_target_in)
				m = panel_status_pkg::MSG_POINTER; // RQ21
			if (bad_command_option_error_in)
				m = panel_status_pkg::MSG_BAD_OPTION; // RQ22
			if (bad_command_error_in)
				m = panel_status_pkg::MSG_BAD_CMD; // RQ22
			if (loop_down_in)
				m = panel_status_pkg::MSG_LOOP_DOWN; // RQ11
			if (loop_fault_in)
			begin
				m = panel_status_pkg::MSG_LOOP_ERROR; // RQ10
				sticky = 1'b1;
			end
			if (setup_checksum_fail_in)
			begin
				m = panel_status_pkg::MSG_SETUP_ERROR;
				sticky = 1'b1;
			end
			if (ram_fail_in || rom_fail_in)
			begin
				m = ram_fail_in ? panel_status_pkg::MSG_RAM_FAIL
					: panel_status_pkg::MSG_ROM_FAIL;
				sticky = 1'b1;
			end
			if (card_id_fail_in != 6'h00)
			begin
				m = panel_status_pkg::MSG_CARD_ID; // RQ24
				sticky = 1'b1; // RQ1
			end
			if (m != panel_status_pkg::MSG_NONE)
			begin
				nxt_state.msg_prev = (state_ff.msg_sticky && !sticky) ? state_ff.msg
					: panel_status_pkg::MSG_NONE;
				nxt_state.msg = m;
				nxt_state.msg_sticky = sticky;
				nxt_state.msg_timer = MSG_HOLD_CYCLES; // RQ2
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_ff <= '0;
			state_ff.edge_rising <= panel_status_pkg::RST_EDGE_RISING; // RQ25
			state_ff.ready_high  <= panel_status_pkg::RST_READY_HIGH; // RQ25
			state_ff.source      <= panel_status_pkg::SRC_EXTERNAL; // RQ25
			state_ff.trig_en     <= panel_status_pkg::RST_TRIG_ENABLE; // RQ25
			state_ff.user_settle <= panel_status_pkg::RST_USER_SETTLE; // RQ25
			state_ff.ready       <= 1'b1;
			state_ff.settled     <= 1'b1;
		end
		else if (!rst_n)
		begin
			state_ff.rst_meta <= 1'b1;
			state_ff.rst_sync <= state_ff.rst_meta;
			state_ff.ext_sync <= nxt_state.ext_sync;
			state_ff.ext_level <= nxt_state.ext_level;
		end
		else
			state_ff <= nxt_state;
	end

	// ****************************************************************
	// Outputs straight from flip-flops, except matrix_ready_out, an XNOR of ready and ready_high
	// ****************************************************************
	assign matrix_ready_out = state_ff.ready ~^ state_ff.ready_high; // RQ6
	assign trigger_out = state_ff.trig;
	assign trigger_overrun_flag_out = state_ff.overrun;
	assign unsettled_trigger_flag_out = state_ff.unsettled;
	assign message_out = state_ff.msg;
	assign remote_led_out = state_ff.remote; // RQ13
	assign talk_led_out = state_ff.talk;
	assign listen_led_out = state_ff.listen;
	assign crosspoint_led_out = state_ff.xp;
	assign make_break_rows_out = state_ff.mb_rows;
	assign break_make_rows_out = state_ff.bm_rows;
	assign clear_setup_out = state_ff.clear_setup;
	assign card_settle_time_out = state_ff.card_settle;
	assign edge_rising_out = state_ff.edge_rising;
	assign ready_high_out = state_ff.ready_high;
	assign source_out = state_ff.source;
	assign trig_enabled_out = state_ff.trig_en;
	assign user_settle_time_out = state_ff.user_settle;

endmodule : matrix_panel_status_logic

// ### test/matrix_panel_status_logic_checker.sv
// Concurrent checks bound to the panel status block.
// Assumes outputs answer a cycle after a taken pulse.
`timescale 1ns/1ps
module matrix_panel_status_logic_checker
(
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        ren_in,
	input wire logic        llo_in,
	input wire logic        listen_addressed_in,
	input wire logic        talk_addressed_in,
	input wire logic        local_key_in,
	input wire logic        cfg_write_in,
	input wire logic [2:0]  cfg_source_in,
	input wire logic        exec_char_in,
	input wire logic        pen_press_in,
	input wire logic        pen_on_target_in,
	input wire logic [5:0]  card_present_in,
	input wire logic [5:0]  card_id_fail_in,
	input wire logic        remote_led_out,
	input wire logic        listen_led_out,
	input wire logic        talk_led_out,
	input wire logic [2:0]  source_out,
	input wire logic [3:0]  message_out,
	input wire logic [15:0] make_break_rows_out,
	input wire logic [15:0] break_make_rows_out
);
	// ************
	// Properties
	// ************
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// Lamps, refusals and messages
	property p_row_excl;
		!(|(make_break_rows_out & break_make_rows_out));
	endproperty
	a_row_excl: assert property (p_row_excl) else $error("row in both modes");
	property p_remote;
		ren_in && listen_addressed_in |-> ##[1:4] remote_led_out;
	endproperty
	a_remote: assert property (p_remote) else $error("remote lamp late");
	property p_listen;
		listen_addressed_in |-> ##[1:4] listen_led_out;
	endproperty
	a_listen: assert property (p_listen) else $error("listen lamp late");
	property p_talk;
		talk_addressed_in |-> ##[1:4] talk_led_out;
	endproperty
	a_talk: assert property (p_talk) else $error("talk lamp late");
	property p_lockout;
		remote_led_out && ren_in && llo_in && local_key_in |=> remote_led_out;
	endproperty
	a_lockout: assert property (p_lockout) else $error("local under lockout");
	property p_cfg_refused;
		remote_led_out && cfg_write_in |=> source_out == $past(source_out);
	endproperty
	a_cfg_refused: assert property (p_cfg_refused) else $error("cfg taken in remote");
	property p_cfg_taken;
		!remote_led_out && cfg_write_in && cfg_source_in <= 3'h4
			|=> source_out == $past(cfg_source_in);
	endproperty
	a_cfg_taken: assert property (p_cfg_taken) else $error("source not loaded");
	property p_not_remote;
		exec_char_in && !remote_led_out
			|-> ##[1:3] message_out == panel_status_pkg::MSG_NOT_REMOTE;
	endproperty
	a_not_remote: assert property (p_not_remote) else $error("no remote error");
	property p_pointer;
		pen_press_in && !pen_on_target_in |-> ##[1:3] message_out == panel_status_pkg::MSG_POINTER;
	endproperty
	a_pointer: assert property (p_pointer) else $error("no pointer error");
	property p_card_id;
		|(card_id_fail_in & card_present_in)
			|-> ##[1:3] message_out == panel_status_pkg::MSG_CARD_ID;
	endproperty
	a_card_id: assert property (p_card_id) else $error("no card_identity_error");
endmodule : matrix_panel_status_logic_checker

bind matrix_panel_status_logic matrix_panel_status_logic_checker i_chk (.*);

// ### test/bus_ctrl_model.sv
// Bus controller levels and trigger pin for the panel bench.
// Assumes calls just after a falling clock edge.
`timescale 1ns/1ps
module bus_ctrl_model
(
	output logic external_trigger_input_out,
	output logic ren_out,
	output logic llo_out,
	output logic listen_out,
	output logic talk_out
);
	// ************
	// Drivers
	// ************
	// Pin idles high so a falling default sees clean edges
	initial
	begin
		external_trigger_input_out = 1'b1;
		{ren_out, llo_out, listen_out, talk_out} = 4'h0;
	end
	task ext(input logic v);
		external_trigger_input_out = v;
	endtask : ext
	// Levels held until the next call, as a real controller does
	task set_bus(input logic r, input logic l, input logic li, input logic t);
		ren_out = r;
		llo_out = l;
		listen_out = li;
		talk_out = t;
	endtask : set_bus
endmodule : bus_ctrl_model

// ### test/matrix_panel_status_logic_tb.sv
// Self-checking bench for the panel status block.
// Assumes short timing parameters: 4 cycles a ms, 20-cycle message hold.
`timescale 1ns/1ps
module matrix_panel_status_logic_tb;
	// ************
	// Signals
	// ************
	logic clk_in, rst_n_in, trig_enable_in, cfg_edge_rising_in, cfg_ready_high_in;
	logic xp_value_in, row_block_in, row_break_make_in, pen_on_target_in;
	logic [2:0]  cfg_source_in;
	logic [16:0] cfg_user_settle_in;
	logic [47:0] card_settle_in;
	logic [5:0]  card_present_in, card_id_fail_in;
	logic [9:0]  xp_addr_in;
	logic [3:0]  row_index_in;
	logic [19:0] pv;
	wire external_trigger_input_in, ren_in, llo_in, listen_addressed_in, talk_addressed_in;
	wire pen_press_in, entry_invalid_in, row_sel_in, xp_write_in, panel_key_in, local_key_in;
	wire operation_in, bad_command_option_error_in, bad_command_error_in;
	wire setup_checksum_fail_in, rom_fail_in, ram_fail_in, loop_down_in, loop_fault_in;
	wire relay_change_in, cfg_write_in, exec_char_in, get_trigger_in, talk_trigger_in;
	wire key_trigger_in, matrix_ready_out, trigger_out, trigger_overrun_flag_out;
	wire unsettled_trigger_flag_out, remote_led_out, talk_led_out, listen_led_out;
	wire clear_setup_out, edge_rising_out, ready_high_out, trig_enabled_out;
	wire [3:0]   message_out;
	wire [575:0] crosspoint_led_out;
	wire [15:0]  make_break_rows_out, break_make_rows_out;
	wire [7:0]   card_settle_time_out;
	wire [2:0]   source_out;
	wire [16:0]  user_settle_time_out;
	int n_fail, cmp_count, cyc, trigs, t0, n;
	int bt[10] = '{6, 8, 9, 10, 7, 11, 12, 18, 19, 3};
	logic [3:0] cd[10] = '{panel_status_pkg::MSG_LOOP_ERROR, panel_status_pkg::MSG_RAM_FAIL,
		panel_status_pkg::MSG_ROM_FAIL, panel_status_pkg::MSG_SETUP_ERROR,
		panel_status_pkg::MSG_LOOP_DOWN, panel_status_pkg::MSG_BAD_CMD,
		panel_status_pkg::MSG_BAD_OPTION, panel_status_pkg::MSG_INVALID_INPUT,
		panel_status_pkg::MSG_POINTER, panel_status_pkg::MSG_NOT_REMOTE};

	// One vector for all strobes keeps the pulse task generic
	assign {pen_press_in, entry_invalid_in, row_sel_in, xp_write_in, panel_key_in, local_key_in,
		operation_in, bad_command_option_error_in, bad_command_error_in, setup_checksum_fail_in,
		rom_fail_in, ram_fail_in, loop_down_in, loop_fault_in, relay_change_in, cfg_write_in,
		exec_char_in, get_trigger_in, talk_trigger_in, key_trigger_in} = pv;

	matrix_panel_status_logic #(.MSG_HOLD_CYCLES(20), .CYCLES_PER_MS(4)) i_dut (.*);
	bus_ctrl_model i_bus (.external_trigger_input_out(external_trigger_input_in), .ren_out(ren_in),
		.llo_out(llo_in), .listen_out(listen_addressed_in), .talk_out(talk_addressed_in));

	// ************
	// Tasks
	// ************
	task close_out;
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task nw(input int k);
		repeat (k) @(negedge clk_in);
	endtask : nw
	task pulse(input int b);
		@(negedge clk_in);
		pv[b] = 1'b1;
		@(negedge clk_in);
		pv = 20'h0;
	endtask : pulse
	task cfg(input logic [2:0] s, input logic e, input logic h, input logic [16:0] u);
		cfg_source_in = s;
		cfg_edge_rising_in = e;
		cfg_ready_high_in = h;
		cfg_user_settle_in = u;
		pulse(4);
		nw(2);
	endtask : cfg

	// Clock, trigger pulse count and hang limit
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	always @(negedge clk_in)
	begin
		trigs += (trigger_out === 1'b1);
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			close_out();
		end
	end

	// ************
	// Sequence
	// ************
	initial
	begin
		{rst_n_in, pv, trig_enable_in, cfg_edge_rising_in, cfg_ready_high_in} = 0;
		{xp_value_in, row_block_in, row_break_make_in, pen_on_target_in} = 4'h0;
		{cfg_source_in, cfg_user_settle_in, card_id_fail_in, xp_addr_in, row_index_in} = 0;
		card_settle_in = 48'h000500030009;
		card_present_in = 6'h14;
		nw(5);
		rst_n_in = 1'b1;
		nw(4);
		chk(edge_rising_out, 0);
		chk(matrix_ready_out, 0);
		chk({trig_enabled_out, source_out, user_settle_time_out}, 0);
		chk(card_settle_time_out, 8'h05);
		cfg(3'h0, 1'b1, 1'b1, 17'h00002);
		chk({edge_rising_out, ready_high_out}, 2'h3);
		cfg(3'h0, 1'b1, 1'b1, 17'h186a0);
		chk(user_settle_time_out, 17'h00002);
		chk(message_out, panel_status_pkg::MSG_INVALID_INPUT);
		// Settling takes card 5 ms plus user 2 ms
		pulse(5);
		chk(matrix_ready_out, 0);
		n = 0;
		while (matrix_ready_out !== 1'b1 && n < 100)
		begin
			nw(1);
			n++;
		end
		chk(n >= 24 && n <= 32, 1);
		// Falling edge ignored when rising is chosen
		trig_enable_in = 1'b1;
		nw(2);
		t0 = trigs;
		i_bus.ext(1'b0);
		nw(8);
		chk(trigs, t0);
		i_bus.ext(1'b1);
		nw(8);
		chk(trigs, t0 + 1);
		nw(40);
		for (int s = 1; s < 4; s++)
		begin
			cfg(s[2:0], 1'b1, 1'b1, 17'h00002);
			t0 = trigs;
			pulse(s - 1);
			nw(2);
			chk(trigs, t0 + 1);
			chk(trigger_overrun_flag_out, 0);
			nw(40);
		end
		// Second of two back to back triggers lands inside settling
		t0 = trigs;
		pulse(2);
		pulse(2);
		nw(2);
		chk(trigs, t0 + 2);
		chk({trigger_overrun_flag_out, unsettled_trigger_flag_out}, 2'h3);
		nw(40);
		pulse(13);
		nw(2);
		chk({trigger_overrun_flag_out, unsettled_trigger_flag_out}, 2'h0);
		cfg(3'h4, 1'b1, 1'b1, 17'h00002);
		// First four are persistent, the rest time out
		for (int i = 0; i < 10; i++)
		begin
			pulse(bt[i]);
			nw(2);
			chk(message_out, cd[i]);
			nw(30);
			chk(message_out, i < 4 ? cd[i] : panel_status_pkg::MSG_NONE);
			pulse(13);
			nw(2);
		end
		card_id_fail_in = 6'h04;
		nw(3);
		card_id_fail_in = 6'h00;
		nw(30);
		chk(message_out, panel_status_pkg::MSG_CARD_ID);
		pulse(15);
		nw(2);
		chk(message_out, panel_status_pkg::MSG_NONE);
		xp_addr_in = 10'h23f;
		xp_value_in = 1'b1;
		pulse(16);
		nw(2);
		chk(crosspoint_led_out[575:574], 2'h2);
		{row_index_in, row_block_in, row_break_make_in} = 6'h0f;
		pulse(17);
		nw(2);
		chk({break_make_rows_out[11], make_break_rows_out[11]}, 2'h2);
		row_break_make_in = 1'b0;
		pulse(17);
		nw(2);
		chk({break_make_rows_out[11], make_break_rows_out[11]}, 2'h1);
		// Remote entry, lamps, refusal and lockout
		t0 = trigs;
		i_bus.set_bus(1'b1, 1'b0, 1'b1, 1'b0);
		nw(3);
		chk({remote_led_out, listen_led_out}, 2'h3);
		i_bus.set_bus(1'b1, 1'b0, 1'b0, 1'b1);
		nw(3);
		chk({talk_led_out, listen_led_out}, 2'h2);
		cfg(3'h1, 1'b0, 1'b1, 17'h00005);
		chk(source_out, 3'h4);
		pulse(3);
		nw(2);
		chk(trigs, t0 + 1);
		i_bus.set_bus(1'b1, 1'b1, 1'b0, 1'b0);
		pulse(14);
		nw(2);
		chk(remote_led_out, 1);
		i_bus.set_bus(1'b1, 1'b0, 1'b0, 1'b0);
		pulse(14);
		nw(2);
		chk(remote_led_out, 0);
		close_out();
	end
endmodule : matrix_panel_status_logic_tb
